// File: rate_gain_pkg.sv
package rate_gain_pkg;
	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_SURROUND_DAC_RATE = 8'h2e;
	localparam logic [7:0] IDX_CENTER_LOWFREQ_DAC_RATE = 8'h30;
	localparam logic [7:0] IDX_ADC_RATE = 8'h32;
	localparam logic [7:0] IDX_CENTER_LOWFREQ_DAC_GAIN = 8'h36;
	localparam logic [7:0] IDX_SURROUND_DAC_GAIN = 8'h38;
	localparam logic [7:0] IDX_RATE_MODE_CTRL = 8'h40;
	localparam logic [7:0] IDX_CONVERTER_STATUS = 8'h41;
	localparam int ADDR_W = 10;
	localparam logic [15:0] RATE_48K = 16'hbb80;
	localparam logic [15:0] RATE_MIN = 16'h1b58;
	localparam logic [15:0] GAIN_RESET = 16'h8888;
	localparam logic [4:0] GAIN_CODE_RESET = 5'h08;
	localparam logic MUTE_RESET = 1'b1;
	// Gain field layout
	localparam int UPPER_MUTE_BIT = 15;
	localparam int UPPER_GAIN_LSB = 8;
	localparam int LOWER_MUTE_BIT = 7;
	localparam int LOWER_GAIN_LSB = 0;
	localparam int GAIN_W = 5;
	localparam logic [15:0] GAIN_MASK = 16'h9f9f;
	// Mode control bits
	localparam int VARIABLE_RATE_BIT = 0;
	localparam int DOUBLE_RATE_BIT = 1;
	localparam int SWAP_BIT = 2;
endpackage

// File: rate_gain_regs.sv
// The APB register port was left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - Each rate register holds a 16-bit unsigned rate in hertz.
// - With variable rate off, every rate reads as 0xBB80 and acts as it, except the DAC rates in double rate mode.
// - With variable rate on, writes set the converter's actual rate.
// - Rates span 0x1B58 to 0xBB80 in one hertz steps.
// - Writing zero to variable rate enable resets all rates to 48 kHz.
// - Double rate mode powers the surround DAC down automatically.
// - Double rate mode powers the centre/LFE DAC down automatically.
// - Gain fields are five bits, 32 steps of minus 1.5 dB.
// - Code 0 is +12 dB, 8 is 0 dB, 31 is -34.5 dB.
// - Centre/LFE register sets both gains; a set mute silences the channel.
// - Surround register has separate left/right gains and mutes.
// - Centre/LFE gain and mute follow logical channels despite output swap.
// - With variable rate off, all converters run at 48 kHz, except the DACs run at 96 kHz in double rate mode.
// - With double rate on, DACs run at twice their programmed rate.
module rate_gain_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rate_gain_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [16:0] surround_dac_rate_eff,
	output logic [16:0] center_lowfreq_dac_rate_eff,
	output logic [15:0] adc_rate_eff,
	output logic surround_dac_powerdown,
	output logic center_lowfreq_dac_powerdown,
	output logic [4:0] center_gain,
	output logic center_mute,
	output logic [4:0] lowfreq_gain,
	output logic lowfreq_mute,
	output logic [4:0] left_surround_gain,
	output logic left_surround_mute,
	output logic [4:0] right_surround_gain,
	output logic right_surround_mute,
	output logic center_lowfreq_output_swap
);
	logic [15:0] sur_rate_q;
	logic [15:0] clf_rate_q;
	logic [15:0] adc_rate_q;
	logic [15:0] clf_gain_q;
	logic [15:0] sur_gain_q;
	logic variable_rate_enable_q;
	logic double_rate_enable_q;
	logic swap_q;
	logic [15:0] sur_rate_d;
	logic [15:0] clf_rate_d;
	logic [15:0] adc_rate_d;
	logic [7:0] idx;
	logic wr;
	logic rd;
	logic hit;
	logic [15:0] rdval;
	logic mode_wr;
	logic clf_gain_wr;
	logic sur_gain_wr;

	// Byte address is four times the register index; low two bits ignored
	assign idx = paddr[rate_gain_pkg::ADDR_W-1:2];
	assign wr = psel & penable & pwrite & pready;
	assign rd = psel & ~penable & ~pwrite;
	assign mode_wr = wr & (idx == rate_gain_pkg::IDX_RATE_MODE_CTRL);
	assign clf_gain_wr = wr & (idx == rate_gain_pkg::IDX_CENTER_LOWFREQ_DAC_GAIN);
	assign sur_gain_wr = wr & (idx == rate_gain_pkg::IDX_SURROUND_DAC_GAIN);

	// Rates outside the span are clamped so the converter never leaves its range
	function automatic logic [15:0] clamp_rate(input logic [15:0] v);
		logic [15:0] r;
		r = v;
		if (v < rate_gain_pkg::RATE_MIN)
		begin
			r = rate_gain_pkg::RATE_MIN;
		end
		else if (v > rate_gain_pkg::RATE_48K)
		begin
			r = rate_gain_pkg::RATE_48K;
		end
		return r;
	endfunction

	always_comb
	begin
		hit = 1'b1;
		rdval = 16'h0000;
		case (idx)
			rate_gain_pkg::IDX_SURROUND_DAC_RATE: rdval = sur_rate_q;
			rate_gain_pkg::IDX_CENTER_LOWFREQ_DAC_RATE: rdval = clf_rate_q;
			rate_gain_pkg::IDX_ADC_RATE: rdval = adc_rate_q;
			rate_gain_pkg::IDX_CENTER_LOWFREQ_DAC_GAIN: rdval = clf_gain_q;
			rate_gain_pkg::IDX_SURROUND_DAC_GAIN: rdval = sur_gain_q;
			rate_gain_pkg::IDX_RATE_MODE_CTRL:
				rdval = {13'h0000, swap_q, double_rate_enable_q, variable_rate_enable_q};
			rate_gain_pkg::IDX_CONVERTER_STATUS:
				rdval = {14'h0000, double_rate_enable_q, double_rate_enable_q};
			default: hit = 1'b0;
		endcase
	end

	// Next rate values: writes stick only while variable rate is on
	always_comb
	begin
		sur_rate_d = sur_rate_q;
		clf_rate_d = clf_rate_q;
		adc_rate_d = adc_rate_q;
		if (mode_wr && !pwdata[rate_gain_pkg::VARIABLE_RATE_BIT])
		begin
			sur_rate_d = rate_gain_pkg::RATE_48K;
			clf_rate_d = rate_gain_pkg::RATE_48K;
			adc_rate_d = rate_gain_pkg::RATE_48K;
		end
		else if (wr && variable_rate_enable_q)
		begin
			if (idx == rate_gain_pkg::IDX_SURROUND_DAC_RATE)
			begin
				sur_rate_d = clamp_rate(pwdata[15:0]);
			end
			if (idx == rate_gain_pkg::IDX_CENTER_LOWFREQ_DAC_RATE)
			begin
				clf_rate_d = clamp_rate(pwdata[15:0]);
			end
			if (idx == rate_gain_pkg::IDX_ADC_RATE)
			begin
				adc_rate_d = clamp_rate(pwdata[15:0]);
			end
		end
	end

	// Surround rate; writes while variable rate is off never reach it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sur_rate_q <= rate_gain_pkg::RATE_48K;
		end
		else
		begin
			sur_rate_q <= sur_rate_d;
		end
	end

	// Centre/LFE rate
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clf_rate_q <= rate_gain_pkg::RATE_48K;
		end
		else
		begin
			clf_rate_q <= clf_rate_d;
		end
	end

	// ADC rate
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_rate_q <= rate_gain_pkg::RATE_48K;
		end
		else
		begin
			adc_rate_q <= adc_rate_d;
		end
	end

	// Mode control bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			variable_rate_enable_q <= 1'b0;
			double_rate_enable_q <= 1'b0;
			swap_q <= 1'b0;
		end
		else if (mode_wr)
		begin
			variable_rate_enable_q <= pwdata[rate_gain_pkg::VARIABLE_RATE_BIT];
			double_rate_enable_q <= pwdata[rate_gain_pkg::DOUBLE_RATE_BIT];
			swap_q <= pwdata[rate_gain_pkg::SWAP_BIT];
		end
	end

	// Centre/LFE gain; reserved bits are masked so they read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clf_gain_q <= rate_gain_pkg::GAIN_RESET;
		end
		else if (clf_gain_wr)
		begin
			clf_gain_q <= pwdata[15:0] & rate_gain_pkg::GAIN_MASK;
		end
	end

	// Surround gain; reserved bits are masked so they read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sur_gain_q <= rate_gain_pkg::GAIN_RESET;
		end
		else if (sur_gain_wr)
		begin
			sur_gain_q <= pwdata[15:0] & rate_gain_pkg::GAIN_MASK;
		end
	end

	// APB slave: no wait state; ready and read data are both flopped from the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
		end
	end

	// Read data is taken in the setup cycle and held until the next read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (rd)
		begin
			prdata <= {16'h0000, rdval};
		end
	end

	// Effective surround rate; doubles under double rate mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			surround_dac_rate_eff <= {1'b0, rate_gain_pkg::RATE_48K};
		end
		else
		begin
			// stored rates already sit at 48 kHz when variable rate is off
			surround_dac_rate_eff <= double_rate_enable_q ? {sur_rate_q, 1'b0}
				: {1'b0, sur_rate_q};
		end
	end

	// Effective centre/LFE rate; one extra bit so the doubled rate never wraps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			center_lowfreq_dac_rate_eff <= {1'b0, rate_gain_pkg::RATE_48K};
		end
		else
		begin
			center_lowfreq_dac_rate_eff <= double_rate_enable_q ? {clf_rate_q, 1'b0}
				: {1'b0, clf_rate_q};
		end
	end

	// Effective ADC rate; double rate mode leaves the ADC alone
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_rate_eff <= rate_gain_pkg::RATE_48K;
		end
		else
		begin
			adc_rate_eff <= adc_rate_q;
		end
	end

	// Power-down follows double rate mode with no separate write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			surround_dac_powerdown <= 1'b0;
			center_lowfreq_dac_powerdown <= 1'b0;
		end
		else
		begin
			surround_dac_powerdown <= double_rate_enable_q;
			center_lowfreq_dac_powerdown <= double_rate_enable_q;
		end
	end

	// Centre/LFE gain outputs; swap only moves pins downstream, never these fields
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			center_gain <= rate_gain_pkg::GAIN_CODE_RESET;
			center_mute <= rate_gain_pkg::MUTE_RESET;
			lowfreq_gain <= rate_gain_pkg::GAIN_CODE_RESET;
			lowfreq_mute <= rate_gain_pkg::MUTE_RESET;
		end
		else
		begin
			// codes pass straight through: step of -1.5 dB from +12 dB
			lowfreq_gain <= clf_gain_q[rate_gain_pkg::UPPER_GAIN_LSB +: rate_gain_pkg::GAIN_W];
			lowfreq_mute <= clf_gain_q[rate_gain_pkg::UPPER_MUTE_BIT];
			center_gain <= clf_gain_q[rate_gain_pkg::LOWER_GAIN_LSB +: rate_gain_pkg::GAIN_W];
			center_mute <= clf_gain_q[rate_gain_pkg::LOWER_MUTE_BIT];
		end
	end

	// Surround gain outputs; left in the upper half, right in the lower
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_surround_gain <= rate_gain_pkg::GAIN_CODE_RESET;
			left_surround_mute <= rate_gain_pkg::MUTE_RESET;
			right_surround_gain <= rate_gain_pkg::GAIN_CODE_RESET;
			right_surround_mute <= rate_gain_pkg::MUTE_RESET;
		end
		else
		begin
			left_surround_gain <=
				sur_gain_q[rate_gain_pkg::UPPER_GAIN_LSB +: rate_gain_pkg::GAIN_W];
			left_surround_mute <= sur_gain_q[rate_gain_pkg::UPPER_MUTE_BIT];
			right_surround_gain <=
				sur_gain_q[rate_gain_pkg::LOWER_GAIN_LSB +: rate_gain_pkg::GAIN_W];
			right_surround_mute <= sur_gain_q[rate_gain_pkg::LOWER_MUTE_BIT];
		end
	end

	// Output swap control is only passed on to the output selector
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			center_lowfreq_output_swap <= 1'b0;
		end
		else
		begin
			center_lowfreq_output_swap <= swap_q;
		end
	end
endmodule

// File: rate_gain_sva.sv
`timescale 1ns/10ps
module rate_gain_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rate_gain_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [16:0] surround_dac_rate_eff,
	input wire logic [15:0] adc_rate_eff,
	input wire logic surround_dac_powerdown,
	input wire logic center_lowfreq_dac_powerdown,
	input wire logic [4:0] center_gain,
	input wire logic center_mute,
	input wire logic [4:0] lowfreq_gain,
	input wire logic lowfreq_mute
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel && !penable |=> pready; endproperty
	property p_ready_one; pready |=> !pready; endproperty
	property p_err_ready; pslverr |-> pready; endproperty
	property p_unmapped; psel && penable && pready && paddr == 10'h3fc |-> pslverr; endproperty
	property p_adc_range; adc_rate_eff >= 16'h1b58 && adc_rate_eff <= 16'hbb80; endproperty
	property p_pd_pair; surround_dac_powerdown == center_lowfreq_dac_powerdown; endproperty
	// Doubled rate is even and at least twice the lowest rate
	property p_double;
		surround_dac_powerdown && $stable(surround_dac_powerdown)
			|-> !surround_dac_rate_eff[0] && surround_dac_rate_eff >= 17'h0_36b0;
	endproperty
	// Last word written to the centre/LFE gain register
	logic [15:0] clf_written;
	always_ff @(posedge pclk)
	begin
		if (psel && penable && pready && pwrite && paddr == 10'h0d8)
		begin
			clf_written <= pwdata[15:0];
		end
	end
	property p_clfe;
		(psel && penable && pready && pwrite && paddr == 10'h0d8)
			|-> ##2 {lowfreq_mute, lowfreq_gain, center_mute, center_gain}
			== {clf_written[15], clf_written[12:8], clf_written[7], clf_written[4:0]};
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	a_ready_one: assert property (p_ready_one) else $error("ready held too long");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	a_adc_range: assert property (p_adc_range) else $error("adc rate out of range");
	a_pd_pair: assert property (p_pd_pair) else $error("powerdowns differ");
	a_double: assert property (p_double) else $error("rate not doubled");
	a_clfe: assert property (p_clfe) else $error("centre lfe gain wrong");
	c_double: cover property (surround_dac_powerdown);
	c_unmapped: cover property (pslverr);
	c_clfe: cover property (psel && penable && pready && pwrite && paddr == 10'h0d8);
endmodule
bind rate_gain_regs rate_gain_sva checker_i (.*);

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, e, surround_dac_powerdown, center_lowfreq_dac_powerdown;
	logic [16:0] surround_dac_rate_eff, center_lowfreq_dac_rate_eff;
	logic [15:0] adc_rate_eff;
	logic [4:0] center_gain, lowfreq_gain, left_surround_gain, right_surround_gain;
	logic center_mute, lowfreq_mute, left_surround_mute, right_surround_mute;
	logic center_lowfreq_output_swap;
	int mismatches = 0, tests_run = 0, cycles = 0;
	logic [9:0] addr_tab [5] = '{10'h0b8, 10'h0c0, 10'h0c8, 10'h0d8, 10'h0e0};
	rate_gain_regs DUT (.*);
	initial forever #4 pclk = ~pclk;
	task automatic end_of_test;
		$display("Compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			end_of_test;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0000_0000);
		chk(r, exp);
	endtask
	// Outputs trail the register by one cycle
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 5; i++)
			rd(addr_tab[i], (i < 3) ? 16'hbb80 : 16'h8888);
		rd(10'h100, 16'h0000);
		rd(10'h104, 16'h0000);
	endtask
	task automatic t_fixed;
		wr(10'h0c8, 16'h1f40);
		rd(10'h0c8, 16'hbb80);
		settle;
		chk(adc_rate_eff, 16'hbb80);
	endtask
	task automatic t_var;
		wr(10'h100, 16'h0001);
		wr(10'h0c8, 16'h0100);
		rd(10'h0c8, 16'h1b58);
		wr(10'h0c8, 16'hffff);
		rd(10'h0c8, 16'hbb80);
		wr(10'h0c8, 16'h1b58);
		rd(10'h0c8, 16'h1b58);
		wr(10'h0b8, 16'hbb80);
		rd(10'h0b8, 16'hbb80);
		wr(10'h0c0, 16'h1f40);
		settle;
		chk(center_lowfreq_dac_rate_eff, 16'h1f40);
		wr(10'h100, 16'h0000);
		for (int i = 0; i < 3; i++)
			rd(addr_tab[i], 16'hbb80);
	endtask
	task automatic t_double;
		wr(10'h100, 16'h0003);
		wr(10'h0b8, 16'h5622);
		settle;
		chk({surround_dac_powerdown, center_lowfreq_dac_powerdown}, 2'h3);
		chk(surround_dac_rate_eff, 17'h0_ac44);
		rd(10'h104, 16'h0003);
		wr(10'h100, 16'h0001);
		settle;
		chk(surround_dac_powerdown, 1'h0);
	endtask
	task automatic t_gain;
		wr(10'h100, 16'h0004);
		wr(10'h0d8, 16'h1f80);
		settle;
		chk({lowfreq_mute, lowfreq_gain, center_mute, center_gain}, 12'h7e0);
		chk(center_lowfreq_output_swap, 1'h1);
		wr(10'h0e0, 32'hffff_ffff);
		rd(10'h0e0, 16'h9f9f);
		wr(10'h0e0, 16'h0881);
		settle;
		chk({left_surround_mute, left_surround_gain}, 6'h08);
		chk({right_surround_mute, right_surround_gain}, 6'h21);
		apb(0, 10'h3fc, 32'h0000_0000);
		chk(e, 1'b1);
		chk(r, 32'h0000_0000);
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_fixed;
		t_var;
		t_double;
		t_gain;
		end_of_test;
	end
endmodule
